/* rtl/sample_buffer_status_access.sv */
// sample buffer store with level, trigger flag, flush and byte read-out registers
//
// Contract
// - byte count is 11 bits: low byte at 0x3C, top three bits at 0x3D[2:0].
// - count rises 6 per sample at 16-bit width, 3 per sample at 8-bit.
// - count of zero means the buffer holds nothing.
// - 0x3D bit 7 is the trigger flag; bits 6 to 3 read zero.
// - any write to 0x3E empties the buffer and clears count and flag.
// - mode select picks fifo, stream, trigger or filo; capacity 681 or 339 samples.
// - width select clear stores 8-bit samples, set stores 16-bit samples.
// - stream mode reads oldest data first through the fifo read pointer.
// - in trigger mode the trigger flag sets on interrupt when count reaches pre-trigger samples times bytes per sample.
`timescale 1ns/1ps
`default_nettype none
module sample_buffer_status_access #(
    parameter int DEPTH       = sample_buffer_pkg::STORE_DEPTH,
    parameter int STAGE_WORDS = sample_buffer_pkg::STAGE_DEPTH
) (
    input  wire logic                            clk_i,                    // 100 MHz system clock
    input  wire logic                            sys_rst_i,                // synchronous reset, high
    input  wire sample_buffer_pkg::reg_req_s     reg_req_i,                // register access strobes
    output logic [7:0]                           reg_rdata_o,              // read data, one cycle after rd
    input  wire logic                            sample_valid_i,           // core offers a sample byte
    output logic                                 sample_ready_o,           // staging queue has room
    input  wire sample_buffer_pkg::sample_byte_s sample_byte_i,            // sample byte from core
    input  wire logic                            buffer_mode_select_high_i,// mode bit 1
    input  wire logic                            buffer_mode_select_low_i, // mode bit 0
    input  wire logic                            sample_width_bit_i,       // 1 = 16-bit samples
    input  wire logic [9:0]                      pre_trigger_count_i,      // samples kept before trigger
    input  wire logic                            physical_irq_i,           // interrupt from an engine
    output logic [10:0]                          stored_byte_count_o,      // current level
    output logic                                 trigger_retained_flag_o   // trigger has occurred
);
    localparam int AW = $clog2(DEPTH);

    sample_buffer_pkg::buffer_mode_e   mode;
    sample_buffer_pkg::trigger_state_e trg_state;
    sample_buffer_pkg::sample_byte_s   stage_byte;

    logic [7:0]    store [DEPTH];
    logic [AW-1:0] wr_ptr;
    logic [AW-1:0] rd_ptr;
    logic [10:0]   level;
    logic [10:0]   cap_bytes;
    logic [2:0]    sample_bytes;
    logic [12:0]   pre_bytes;
    logic [12:0]   limit;
    logic          at_limit;
    logic          drop_mode;
    logic          stage_valid;
    logic          store_room;
    logic          store_en;
    logic          drop_oldest;
    logic          flush;
    logic          data_rd;
    logic          data_take;
    logic          trig_hit;
    logic [AW-1:0] filo_ptr;

    assign mode = sample_buffer_pkg::buffer_mode_e'({buffer_mode_select_high_i, buffer_mode_select_low_i});

    // sample geometry from the width select
    assign sample_bytes = sample_width_bit_i ? sample_buffer_pkg::BYTES_WIDE
                                             : sample_buffer_pkg::BYTES_NARROW;
    assign cap_bytes    = sample_width_bit_i ? sample_buffer_pkg::CAP_BYTES_WIDE
                                             : sample_buffer_pkg::CAP_BYTES_NARROW;
    assign pre_bytes    = 13'(pre_trigger_count_i) * 13'(sample_bytes);

    // register strobes decoded
    assign flush     = reg_req_i.wr && (reg_req_i.addr == sample_buffer_pkg::ADDR_FLUSH);
    assign data_rd   = reg_req_i.rd && (reg_req_i.addr == sample_buffer_pkg::ADDR_DATA_OUT) && !flush;
    assign data_take = data_rd && (level != 11'h000);

    // limit: before the trigger keep only the pre-trigger samples, else the capacity
    always_comb begin
        limit = 13'(cap_bytes);
        if (mode == sample_buffer_pkg::MODE_TRIGGER && trg_state == sample_buffer_pkg::TRG_ARMED
            && pre_bytes < 13'(cap_bytes)) begin
            limit = pre_bytes;
        end
    end
    assign at_limit  = 13'(level) >= limit;
    // stream, filo and an armed trigger discard oldest when full; fifo and held trigger stall
    assign drop_mode = (mode == sample_buffer_pkg::MODE_STREAM) || (mode == sample_buffer_pkg::MODE_FILO)
                       || (mode == sample_buffer_pkg::MODE_TRIGGER && trg_state == sample_buffer_pkg::TRG_ARMED);
    // a data read takes the store this cycle, so a byte waits in the staging queue
    assign store_room  = !data_rd && !flush && (!at_limit || drop_mode);
    assign store_en    = stage_valid && store_room;
    assign drop_oldest = store_en && at_limit;
    assign filo_ptr    = wr_ptr - AW'(1);

    // staging queue between the core and the store
    stage_fifo #(
        .WIDTH (sample_buffer_pkg::BYTE_W),
        .DEPTH (STAGE_WORDS)
    ) u_stage (
        .clk_i       (clk_i),
        .sys_rst_i   (sys_rst_i),
        .flush_i     (flush),
        .in_valid_i  (sample_valid_i),
        .in_ready_o  (sample_ready_o),
        .in_data_i   (sample_byte_i),
        .out_valid_o (stage_valid),
        .out_ready_i (store_room),
        .out_data_o  (stage_byte)
    );

    // byte store write
    always_ff @(posedge clk_i) begin
        if (store_en) begin
            store[wr_ptr] <= stage_byte.data;
        end
    end

    // write pointer: advances on store, steps back on a filo read
    always_ff @(posedge clk_i) begin
        if (sys_rst_i || flush) begin
            wr_ptr <= '0;
        end else if (store_en) begin
            wr_ptr <= wr_ptr + AW'(1);
        end else if (data_take && mode == sample_buffer_pkg::MODE_FILO) begin
            wr_ptr <= filo_ptr;
        end
    end

    // read pointer marks the oldest byte
    always_ff @(posedge clk_i) begin
        if (sys_rst_i || flush) begin
            rd_ptr <= '0;
        end else if (drop_oldest) begin
            rd_ptr <= rd_ptr + AW'(1);
        end else if (data_take && mode != sample_buffer_pkg::MODE_FILO) begin
            rd_ptr <= rd_ptr + AW'(1);
        end
    end

    // byte level
    always_ff @(posedge clk_i) begin
        if (sys_rst_i || flush) begin
            level <= sample_buffer_pkg::LEVEL_RESET;
        end else if (data_take) begin
            level <= level - 11'h001;
        end else if (store_en && !drop_oldest) begin
            level <= level + 11'h001;
        end
    end

    // trigger detection, held until flush
    assign trig_hit = (mode == sample_buffer_pkg::MODE_TRIGGER) && physical_irq_i && (13'(level) >= pre_bytes);
    always_ff @(posedge clk_i) begin
        if (sys_rst_i || flush) begin
            trg_state <= sample_buffer_pkg::TRG_ARMED;
        end else begin
            case (trg_state)
                sample_buffer_pkg::TRG_ARMED: begin
                    if (trig_hit) begin
                        trg_state <= sample_buffer_pkg::TRG_HELD;
                    end
                end
                sample_buffer_pkg::TRG_HELD: begin
                    trg_state <= sample_buffer_pkg::TRG_HELD;
                end
                default: begin
                    trg_state <= sample_buffer_pkg::TRG_ARMED;
                end
            endcase
        end
    end

    // register read data, one cycle after the strobe
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            reg_rdata_o <= sample_buffer_pkg::RDATA_RESET;
        end else if (reg_req_i.rd) begin
            case (reg_req_i.addr)
                sample_buffer_pkg::ADDR_LEVEL_LOW: begin
                    reg_rdata_o <= level[7:0];
                end
                sample_buffer_pkg::ADDR_LEVEL_HIGH: begin
                    reg_rdata_o <= {trg_state == sample_buffer_pkg::TRG_HELD, 4'h0,
                                    level[10:8]};
                end
                sample_buffer_pkg::ADDR_DATA_OUT: begin
                    if (!data_take) begin
                        reg_rdata_o <= 8'h00;
                    end else if (mode == sample_buffer_pkg::MODE_FILO) begin
                        reg_rdata_o <= store[filo_ptr];
                    end else begin
                        reg_rdata_o <= store[rd_ptr];
                    end
                end
                default: begin
                    reg_rdata_o <= 8'h00;
                end
            endcase
        end
    end

    assign stored_byte_count_o     = level;
    assign trigger_retained_flag_o = (trg_state == sample_buffer_pkg::TRG_HELD);

    // checks
    a_level_low_read: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        reg_req_i.rd && reg_req_i.addr == sample_buffer_pkg::ADDR_LEVEL_LOW
        |=> reg_rdata_o == $past(level[7:0]))
        else $error("low level byte mismatch");

    a_level_high_read: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        reg_req_i.rd && reg_req_i.addr == sample_buffer_pkg::ADDR_LEVEL_HIGH
        |=> reg_rdata_o[6:3] == 4'h0 && reg_rdata_o[2:0] == $past(level[10:8])
            && reg_rdata_o[7] == $past(trigger_retained_flag_o))
        else $error("high level register mismatch");

    a_store_step: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        store_en && !drop_oldest |=> level == $past(level) + 11'h001)
        else $error("store did not raise level by one byte");

    a_empty_read: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        data_rd && level == 11'h000 && !store_en |=> level == 11'h000 && reg_rdata_o == 8'h00)
        else $error("read of empty buffer changed level");

    a_flush_clears: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        flush |=> level == 11'h000 && !trigger_retained_flag_o && wr_ptr == rd_ptr && !stage_valid)
        else $error("flush left status behind");

    a_read_step: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        data_take |=> level == $past(level) - 11'h001)
        else $error("read did not drop level by one");

    a_level_cap: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        $stable(sample_width_bit_i) && level <= cap_bytes |=> level <= cap_bytes)
        else $error("level passed capacity");

    a_width_geometry: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        sample_width_bit_i |-> cap_bytes == 11'h7F2 && sample_bytes == 3'h6)
        else $error("wide sample geometry wrong");

    a_stream_oldest: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        data_take && mode == sample_buffer_pkg::MODE_STREAM
        |=> rd_ptr == $past(rd_ptr) + AW'(1) && reg_rdata_o == $past(store[rd_ptr]))
        else $error("stream read not oldest first");

    a_trigger_cause: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        $rose(trigger_retained_flag_o) |-> $past(trig_hit))
        else $error("trigger flag set without cause");

    a_trigger_held: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        trigger_retained_flag_o && !flush |=> trigger_retained_flag_o)
        else $error("trigger flag dropped without flush");

    a_filo_newest: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        data_take && mode == sample_buffer_pkg::MODE_FILO
        |=> reg_rdata_o == $past(store[filo_ptr]) && wr_ptr == $past(filo_ptr))
        else $error("filo read not newest first");

    a_drop_keeps_level: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        drop_oldest |=> level == $past(level))
        else $error("discarding oldest byte changed level");
endmodule
`default_nettype wire

/* rtl/sample_buffer_pkg.sv */
// constants, types and register map of the sample buffer status and read-out block
package sample_buffer_pkg;
    // register offsets
    localparam logic [7:0]  ADDR_LEVEL_LOW      = 8'h3C;
    localparam logic [7:0]  ADDR_LEVEL_HIGH     = 8'h3D;
    localparam logic [7:0]  ADDR_FLUSH          = 8'h3E;
    localparam logic [7:0]  ADDR_DATA_OUT       = 8'h3F;
    // field positions in the second status register
    localparam int          TRIG_FLAG_BIT       = 7;
    localparam int          LEVEL_HIGH_BITS     = 3;
    // store geometry
    localparam int          LEVEL_W             = 11;
    localparam int          STORE_DEPTH         = 2048;
    localparam int          PRE_TRIG_W          = 10;
    localparam logic [10:0] CAP_BYTES_NARROW    = 11'h7FB;  // 681 samples of 3 bytes
    localparam logic [10:0] CAP_BYTES_WIDE      = 11'h7F2;  // 339 samples of 6 bytes
    localparam logic [2:0]  BYTES_NARROW        = 3'h3;
    localparam logic [2:0]  BYTES_WIDE          = 3'h6;
    // reset values
    localparam logic [10:0] LEVEL_RESET         = 11'h000;
    localparam logic [7:0]  RDATA_RESET         = 8'h00;
    // staging queue in front of the store
    localparam int          STAGE_DEPTH         = 8;
    localparam int          BYTE_W              = 8;

    typedef enum logic [1:0] {
        MODE_FIFO    = 2'b00,
        MODE_STREAM  = 2'b01,
        MODE_TRIGGER = 2'b10,
        MODE_FILO    = 2'b11
    } buffer_mode_e;

    typedef enum logic [1:0] {
        TRG_ARMED = 2'b01,
        TRG_HELD  = 2'b10
    } trigger_state_e;

    typedef struct packed {
        logic [7:0] addr;
        logic       wr;
        logic       rd;
        logic [7:0] wdata;
    } reg_req_s;

    typedef struct packed {
        logic [7:0] data;
    } sample_byte_s;
endpackage

/* rtl/stage_fifo.sv */
// small first-in first-out queue with valid and ready on both sides
`timescale 1ns/1ps
`default_nettype none
module stage_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8
) (
    input  wire logic             clk_i,      // system clock
    input  wire logic             sys_rst_i,  // synchronous reset, high
    input  wire logic             flush_i,    // drop all entries
    input  wire logic             in_valid_i, // write side offers a word
    output logic                  in_ready_o, // queue has room
    input  wire logic [WIDTH-1:0] in_data_i,  // word written
    output logic                  out_valid_o,// queue holds a word
    input  wire logic             out_ready_i,// drain side takes the word
    output logic      [WIDTH-1:0] out_data_o  // oldest word
);
    localparam int PW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [PW-1:0]    wr_ptr;
    logic [PW-1:0]    rd_ptr;
    logic [PW:0]      fill;
    logic             push;
    logic             pop;

    // honest full and empty from the fill count
    assign in_ready_o  = (fill != PW'(0) + (PW+1)'(DEPTH)) && !flush_i;
    assign out_valid_o = (fill != '0) && !flush_i;
    assign out_data_o  = mem[rd_ptr];
    assign push        = in_valid_i && in_ready_o;
    assign pop         = out_valid_o && out_ready_i;

    // storage write
    always_ff @(posedge clk_i) begin
        if (push) begin
            mem[wr_ptr] <= in_data_i;
        end
    end

    // pointers and fill level
    always_ff @(posedge clk_i) begin
        if (sys_rst_i || flush_i) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            fill   <= '0;
        end else begin
            if (push) begin
                wr_ptr <= (wr_ptr == PW'(DEPTH - 1)) ? '0 : wr_ptr + PW'(1);
            end
            if (pop) begin
                rd_ptr <= (rd_ptr == PW'(DEPTH - 1)) ? '0 : rd_ptr + PW'(1);
            end
            fill <= fill + (PW+1)'(push) - (PW+1)'(pop);
        end
    end
endmodule
`default_nettype wire

/* test/sample_source.sv */
// behavioural sample core that offers bytes to the staging queue by valid and ready
`timescale 1ns/1ps
`default_nettype none
module sample_source (
    input  wire logic                      clk_i,     // system clock
    input  wire logic                      sys_rst_i, // synchronous reset, high
    input  wire logic                      start_i,   // load a new run of bytes
    input  wire logic                      stall_i,   // hold back new bytes
    input  wire logic [11:0]               count_i,   // bytes in the run
    input  wire logic [7:0]                base_i,    // first byte value
    input  wire logic                      ready_i,   // queue has room
    output logic                           valid_o,   // byte offered
    output var sample_buffer_pkg::sample_byte_s byte_o, // offered byte
    output logic                           busy_o     // run not finished
);
    logic [11:0] left;
    logic [7:0]  nxt;
    logic        took;
    logic        start_seen;
    // handshake and start seen at the sampling edge
    always @(posedge clk_i) begin
        took       <= !sys_rst_i && valid_o && ready_i;
        start_seen <= !sys_rst_i && start_i;
    end
    // an offer is held until taken; released data toggles so it never looks valid
    always @(negedge clk_i) begin
        if (sys_rst_i) begin
            left = 12'h000;
            nxt  = 8'h00;
        end else if (start_seen) begin
            left = count_i;
            nxt  = base_i;
        end else if (took) begin
            left = left - 12'h001;
            nxt  = nxt + 8'h01;
        end
        valid_o     = (left != 12'h000) && ((valid_o && !took) || !stall_i);
        byte_o.data = valid_o ? nxt : ~byte_o.data;
    end
    assign busy_o = (left != 12'h000);
endmodule
`default_nettype wire

/* test/sample_buffer_status_access_bench.sv */
// self-checking testbench of the sample buffer status and read-out block
`timescale 1ns/1ps
`default_nettype none
module sample_buffer_status_access_bench;
    logic                            clk_i;
    logic                            sys_rst_i;
    sample_buffer_pkg::reg_req_s     req;
    logic [7:0]                      rdata;
    logic                            s_valid;
    logic                            s_ready;
    sample_buffer_pkg::sample_byte_s s_byte;
    logic [1:0]                      mode;
    logic                            width_bit;
    logic [9:0]                      pre_count;
    logic                            irq;
    logic [10:0]                     level;
    logic                            flag;
    logic                            src_start;
    logic                            src_stall;
    logic [11:0]                     src_count;
    logic [7:0]                      src_base;
    logic                            src_busy;
    int                              errors;
    int                              checked;

    sample_buffer_status_access dut_u (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .reg_req_i(req),
        .reg_rdata_o(rdata), .sample_valid_i(s_valid), .sample_ready_o(s_ready), .sample_byte_i(s_byte),
        .buffer_mode_select_high_i(mode[1]), .buffer_mode_select_low_i(mode[0]),
        .sample_width_bit_i(width_bit), .pre_trigger_count_i(pre_count), .physical_irq_i(irq),
        .stored_byte_count_o(level), .trigger_retained_flag_o(flag));
    sample_source src_u (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .start_i(src_start), .stall_i(src_stall),
        .count_i(src_count), .base_i(src_base), .ready_i(s_ready), .valid_o(s_valid), .byte_o(s_byte),
        .busy_o(src_busy));

    // 100 MHz clock
    always #5 clk_i = ~clk_i;

    task automatic chk(input logic [10:0] seen, input logic [10:0] exp);
        checked++;
        if (seen !== exp) begin
            errors++;
            $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    // one write strobe, then an idle cycle
    task automatic reg_wr(input logic [7:0] a, input logic [7:0] v);
        @(negedge clk_i);
        req.addr  = a;
        req.wdata = v;
        req.wr    = 1'b1;
        @(negedge clk_i);
        req.wr = 1'b0;
    endtask
    // one read strobe; the byte stands in the following cycle
    task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
        @(negedge clk_i);
        req.addr = a;
        req.rd   = 1'b1;
        @(negedge clk_i);
        req.rd = 1'b0;
        chk({3'h0, rdata}, {3'h0, exp});
    endtask
    task automatic push(input logic [11:0] n, input logic [7:0] b);
        @(negedge clk_i);
        src_count = n;
        src_base  = b;
        src_start = 1'b1;
        @(negedge clk_i);
        src_start = 1'b0;
    endtask
    // bounded wait until the core is done or refused, then let the queue settle
    task automatic wait_src;
        int n;
        n = 0;
        repeat (2) @(negedge clk_i);
        while (src_busy && s_ready && n < 5000) begin
            @(negedge clk_i);
            n++;
        end
        // a core that never finishes is a failure in its own right
        if (n >= 5000) begin
            errors++;
            test_done;
        end
        repeat (12) @(negedge clk_i);
    endtask
    task automatic test_done;
        $display("comparisons %0d mismatches %0d", checked, errors);
        if (errors == 0 && checked > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    // watchdog sized well above the longest fill and drain
    initial begin
        repeat (40000) @(posedge clk_i);
        errors++;
        test_done;
    end

    // main sequence
    initial begin
        clk_i = 1'b0; sys_rst_i = 1'b1; req = '0; mode = sample_buffer_pkg::MODE_FIFO; width_bit = 1'b0;
        pre_count = 10'h000; irq = 1'b0; src_start = 1'b0; src_stall = 1'b0; src_count = 12'h000;
        src_base = 8'h00; errors = 0; checked = 0;
        repeat (6) @(negedge clk_i);
        sys_rst_i = 1'b0;
        // empty after reset, unmapped and write-only places read zero
        chk(level, 11'h000);
        rd_chk(sample_buffer_pkg::ADDR_LEVEL_LOW, 8'h00);
        rd_chk(sample_buffer_pkg::ADDR_LEVEL_HIGH, 8'h00);
        rd_chk(sample_buffer_pkg::ADDR_DATA_OUT, 8'h00);
        rd_chk(8'h10, 8'h00);
        rd_chk(sample_buffer_pkg::ADDR_FLUSH, 8'h00);
        // two narrow samples, read back one byte at a time
        push(12'h006, 8'h10);
        wait_src;
        chk(level, 11'h006);
        for (int i = 0; i < 6; i++) begin
            rd_chk(sample_buffer_pkg::ADDR_DATA_OUT, 8'h10 + 8'(i));
            chk(level, 11'h005 - 11'(i));
        end
        // two wide samples with the core stalling mid-run
        width_bit = 1'b1;
        push(12'h00C, 8'h20);
        repeat (3) @(negedge clk_i);
        src_stall = 1'b1;
        repeat (20) @(negedge clk_i);
        src_stall = 1'b0;
        wait_src;
        chk(level, 11'h00C);
        rd_chk(sample_buffer_pkg::ADDR_LEVEL_LOW, 8'h0C);
        reg_wr(sample_buffer_pkg::ADDR_LEVEL_LOW, 8'hFF);
        chk(level, 11'h00C);
        reg_wr(sample_buffer_pkg::ADDR_FLUSH, 8'hA5);
        chk(level, 11'h000);
        rd_chk(sample_buffer_pkg::ADDR_DATA_OUT, 8'h00);
        // last-in first-out returns the newest byte
        mode = sample_buffer_pkg::MODE_FILO;
        width_bit = 1'b0;
        push(12'h006, 8'h40);
        wait_src;
        rd_chk(sample_buffer_pkg::ADDR_DATA_OUT, 8'h45);
        reg_wr(sample_buffer_pkg::ADDR_FLUSH, 8'h00);
        // fifo stops at capacity, the queue fills and refuses, then full drain
        mode = sample_buffer_pkg::MODE_FIFO;
        push(12'h803, 8'h00);
        wait_src;
        chk(level, 11'h7FB);
        chk({10'h000, s_ready}, 11'h000);
        rd_chk(sample_buffer_pkg::ADDR_LEVEL_LOW, 8'hFB);
        rd_chk(sample_buffer_pkg::ADDR_LEVEL_HIGH, 8'h07);
        for (int i = 0; i < 2051; i++)
            rd_chk(sample_buffer_pkg::ADDR_DATA_OUT, 8'(i));
        chk(level, 11'h000);
        // stream keeps the newest bytes and reads the oldest kept first
        mode = sample_buffer_pkg::MODE_STREAM;
        push(12'h819, 8'h00);
        wait_src;
        chk(level, 11'h7FB);
        rd_chk(sample_buffer_pkg::ADDR_DATA_OUT, 8'h1E);
        reg_wr(sample_buffer_pkg::ADDR_FLUSH, 8'h3C);
        // trigger: no flag while short of the pre-trigger samples
        mode = sample_buffer_pkg::MODE_TRIGGER;
        pre_count = 10'h002;
        @(negedge clk_i);
        irq = 1'b1;
        @(negedge clk_i);
        irq = 1'b0;
        chk({10'h000, flag}, 11'h000);
        push(12'h00C, 8'h80);
        wait_src;
        chk(level, 11'h006);
        @(negedge clk_i);
        irq = 1'b1;
        @(negedge clk_i);
        irq = 1'b0;
        chk({10'h000, flag}, 11'h001);
        rd_chk(sample_buffer_pkg::ADDR_LEVEL_HIGH, 8'h80);
        rd_chk(sample_buffer_pkg::ADDR_DATA_OUT, 8'h86);
        reg_wr(sample_buffer_pkg::ADDR_FLUSH, 8'h01);
        chk({level[9:0], flag}, 11'h000);
        test_done;
    end
endmodule
`default_nettype wire
